// ===== hdl/rf_frontend_timer_control.sv
// timer section control with apb register access
// Overview of operation
// - masked write updates only selected run bits
// - run bits 7..4 show timers 3..0 live
// - masked one starts, masked zero stops
// - stop timer0 after first received bits
// - stop-on-receive ignored in lfo modes
// - mode 00 manual, 01 starts at tx end
// - modes 10/11 lfo trimming, rising edges
// - auto-restart reloads, otherwise stop at zero; mode 10 holds timer0 at zero, running, with no underflow
// - underflow sets sticky interrupt flag
// - clock select 00 fast, 01 slow
// - clock select 10 timer2, 11 timer1 underflow
// - start event loads 16-bit reload value
// - reload writes apply at next start
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "rf_timer_cfg.svh"

module rf_frontend_timer_control #(
  parameter int TIMERS = 4
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rfCarrier,
  input  wire logic        lfoPin,
  input  wire logic        txEnd,
  input  wire logic        rxFirstBits,
  output logic             irq,
  output logic [3:0]       timerRunning
);

  rf_timer_pkg::apb_request_type       req;
  rf_timer_pkg::bus_state_type         busState;
  rf_timer_pkg::bus_state_type         next_busState;
  rf_timer_pkg::timer_zero_config_type t0cfg;
  rf_timer_pkg::timer_zero_config_type next_t0cfg;
  logic [3:0]  runFlag;
  logic [3:0]  next_runFlag;
  logic [15:0] count [TIMERS];
  logic [15:0] next_count [TIMERS];
  logic [15:0] reloadVal [TIMERS];
  logic [15:0] next_reloadVal [TIMERS];
  logic [3:0]  uflow;
  logic [3:0]  next_uflow;
  logic [3:0]  status;
  logic [3:0]  next_status;
  logic [3:0]  enable;
  logic [3:0]  next_enable;
  logic [5:0]  divider;
  logic [5:0]  next_divider;
  logic [1:0]  carrierSync;
  logic        carrierLast;
  logic [1:0]  lfoSync;
  logic        lfoLast;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_irq;
  logic        fastTick;
  logic        slowTick;
  logic        lfoEdge;
  logic [3:0]  tick;
  logic [5:0]  index;
  logic        writeNow;
  logic        readNow;
  logic [3:0]  clearMask;
  logic        mapped;

  function automatic logic [3:0] maskedRun(
    input logic [3:0] run,
    input logic [7:0] wr
  );
    logic [3:0] mask;
    logic [3:0] value;
    mask  = wr[`RFT_MASK_POS +: 4];
    value = wr[`RFT_RUN_POS +: 4];
    return (run & ~mask) | (value & mask);
  endfunction : maskedRun

  function automatic logic pickTick(
    input rf_timer_pkg::input_clock_type sel,
    input logic                          fast,
    input logic                          slow,
    input logic                          u2,
    input logic                          u1
  );
    logic t;
    t = fast;
    unique case (sel)
      rf_timer_pkg::CLK_FAST:   t = fast;
      rf_timer_pkg::CLK_SLOW:   t = slow;
      rf_timer_pkg::CLK_TIMER2: t = u2;
      rf_timer_pkg::CLK_TIMER1: t = u1;
    endcase
    return t;
  endfunction : pickTick

  assign req          = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign index        = req.addr[7:2];
  assign pready       = busState[1];
  assign timerRunning = runFlag;

  // pins are sampled through two flops; only the second is read
  assign fastTick = carrierSync[1] & ~carrierLast;
  assign slowTick = fastTick & (divider == 6'(`RFT_SLOW_DIV - 1));
  assign lfoEdge  = lfoSync[1] & ~lfoLast;

  // cascade uses last cycle's underflow, so a chain adds one cycle per stage
  always_comb begin
    tick    = {4{fastTick}};
    tick[0] = pickTick(t0cfg.inputClockSelect, fastTick, slowTick, uflow[2], uflow[1]);
  end

  // unmapped indices answer with pslverr and read as zero
  always_comb begin
    mapped = 1'b1;
    unique case (index)
      `RFT_IDX_RUN,
      `RFT_IDX_T0CFG,
      `RFT_IDX_RLD_HI,
      `RFT_IDX_RLD_LO,
      `RFT_IDX_CNT_HI,
      `RFT_IDX_CNT_LO,
      `RFT_IDX_IRQ_STAT,
      `RFT_IDX_IRQ_EN,
      `RFT_IDX_IRQ_CLR,
      `RFT_IDX_AUX_RLD1,
      `RFT_IDX_AUX_RLD2,
      `RFT_IDX_AUX_RLD3: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // a write lands on the edge that samples pready, never on the first access edge
  always_comb begin
    next_busState = busState;
    readNow       = 1'b0;
    writeNow      = 1'b0;
    unique case (busState)
      rf_timer_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          next_busState = rf_timer_pkg::BUS_DONE;
          readNow       = 1'b1;
        end
      end
      rf_timer_pkg::BUS_DONE: begin
        next_busState = rf_timer_pkg::BUS_IDLE;
        writeNow      = psel & penable & req.write & mapped;
      end
    endcase
  end

  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (readNow) begin
      next_prdata  = 32'h0;
      next_pslverr = ~mapped;
      unique case (index)
        `RFT_IDX_RUN:      next_prdata[7:0]  = {runFlag, 4'h0};
        `RFT_IDX_T0CFG:    next_prdata[7:0]  = t0cfg;
        `RFT_IDX_RLD_HI:   next_prdata[7:0]  = reloadVal[0][15:8];
        `RFT_IDX_RLD_LO:   next_prdata[7:0]  = reloadVal[0][7:0];
        `RFT_IDX_CNT_HI:   next_prdata[7:0]  = count[0][15:8];
        `RFT_IDX_CNT_LO:   next_prdata[7:0]  = count[0][7:0];
        `RFT_IDX_IRQ_STAT: next_prdata[3:0]  = status;
        `RFT_IDX_IRQ_EN:   next_prdata[3:0]  = enable;
        `RFT_IDX_IRQ_CLR:  next_prdata       = 32'h0; // clear register is write-only
        `RFT_IDX_AUX_RLD1: next_prdata[15:0] = reloadVal[1];
        `RFT_IDX_AUX_RLD2: next_prdata[15:0] = reloadVal[2];
        `RFT_IDX_AUX_RLD3: next_prdata[15:0] = reloadVal[3];
        default:           next_prdata       = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_t0cfg     = t0cfg;
    next_enable    = enable;
    next_reloadVal = reloadVal;
    clearMask      = 4'h0;
    if (writeNow) begin
      unique case (index)
        `RFT_IDX_T0CFG: begin
          next_t0cfg       = req.wdata[7:0];
          next_t0cfg.rsvd6 = 1'b0;
          next_t0cfg.rsvd2 = 1'b0;
        end
        // reload bytes only feed the next start, the count is untouched
        `RFT_IDX_RLD_HI:   next_reloadVal[0][15:8] = req.wdata[7:0];
        `RFT_IDX_RLD_LO:   next_reloadVal[0][7:0]  = req.wdata[7:0];
        `RFT_IDX_IRQ_EN:   next_enable             = req.wdata[3:0];
        `RFT_IDX_IRQ_CLR:  clearMask               = req.wdata[3:0];
        `RFT_IDX_AUX_RLD1: next_reloadVal[1]       = req.wdata[15:0];
        `RFT_IDX_AUX_RLD2: next_reloadVal[2]       = req.wdata[15:0];
        `RFT_IDX_AUX_RLD3: next_reloadVal[3]       = req.wdata[15:0];
        `RFT_IDX_IRQ_STAT: begin
          // status only falls through the clear register, so direct writes are dropped
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    logic [3:0] swRun;
    logic [3:0] swMask;
    logic       lfoMode;
    swRun        = maskedRun(runFlag, req.wdata[7:0]);
    swMask       = writeNow && (index == `RFT_IDX_RUN) ? req.wdata[3:0] : 4'h0;
    lfoMode      = t0cfg.startModeSelect[1];
    next_runFlag = runFlag;
    next_count   = count;
    next_uflow   = 4'h0;
    for (int i = 0; i < TIMERS; i++) begin
      if (runFlag[i] && tick[i]) begin
        if (count[i] != 16'h0) begin
          next_count[i] = count[i] - 16'h1;
        end else if (i == 0 && t0cfg.startModeSelect == rf_timer_pkg::START_LFO) begin
          next_count[i] = count[i];
        end else begin
          next_uflow[i] = 1'b1;
          if (i == 0 && t0cfg.autoReloadEnable) begin
            next_count[i] = reloadVal[i];
          end else begin
            next_runFlag[i] = 1'b0;
          end
        end
      end
    end
    if (t0cfg.stopOnReceive && !lfoMode && rxFirstBits) begin
      next_runFlag[0] = 1'b0;
    end
    if (t0cfg.startModeSelect == rf_timer_pkg::START_TX_END && txEnd) begin
      next_runFlag[0] = 1'b1;
      next_count[0]   = reloadVal[0];
    end
    if (lfoMode && lfoEdge) begin
      next_runFlag[0] = ~runFlag[0];
      next_count[0]   = runFlag[0] ? next_count[0] : reloadVal[0];
    end
    // software has the last word over the automatic events of the same cycle
    for (int i = 0; i < TIMERS; i++) begin
      if (swMask[i]) begin
        next_runFlag[i] = swRun[i];
        if (swRun[i]) begin
          next_count[i] = reloadVal[i];
        end
      end
    end
  end

  always_comb begin
    next_divider = fastTick ? 6'(divider + 6'h1) : divider;
    next_status  = (status & ~clearMask) | next_uflow;
    next_irq     = |(next_status & next_enable);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busState    <= rf_timer_pkg::BUS_IDLE;
      prdata      <= 32'h0;
      pslverr     <= 1'b0;
      t0cfg       <= `RFT_T0CFG_RESET;
      runFlag     <= 4'h0;
      uflow       <= 4'h0;
      status      <= 4'h0;
      enable      <= 4'h0;
      irq         <= 1'b0;
      divider     <= 6'h0;
      carrierSync <= 2'h0;
      carrierLast <= 1'b0;
      lfoSync     <= 2'h0;
      lfoLast     <= 1'b0;
      for (int i = 0; i < TIMERS; i++) begin
        count[i]     <= 16'h0;
        reloadVal[i] <= `RFT_RLD_RESET;
      end
    end else begin
      busState    <= next_busState;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
      t0cfg       <= next_t0cfg;
      runFlag     <= next_runFlag;
      uflow       <= next_uflow;
      status      <= next_status;
      enable      <= next_enable;
      irq         <= next_irq;
      divider     <= next_divider;
      carrierSync <= {carrierSync[0], rfCarrier};
      carrierLast <= carrierSync[1];
      lfoSync     <= {lfoSync[0], lfoPin};
      lfoLast     <= lfoSync[1];
      count       <= next_count;
      reloadVal   <= next_reloadVal;
    end
  end

endmodule : rf_frontend_timer_control

// ===== hdl/rf_timer_cfg.svh
// register indices, field positions, reset values and timing counts of the timer section
`ifndef RF_TIMER_CFG_SVH
`define RF_TIMER_CFG_SVH
`define RFT_IDX_RUN       6'h0e
`define RFT_IDX_T0CFG     6'h0f
`define RFT_IDX_RLD_HI    6'h10
`define RFT_IDX_RLD_LO    6'h11
`define RFT_IDX_CNT_HI    6'h12
`define RFT_IDX_CNT_LO    6'h13
`define RFT_IDX_IRQ_STAT  6'h20
`define RFT_IDX_IRQ_EN    6'h21
`define RFT_IDX_IRQ_CLR   6'h22
`define RFT_IDX_AUX_RLD1  6'h23
`define RFT_IDX_AUX_RLD2  6'h24
`define RFT_IDX_AUX_RLD3  6'h25
`define RFT_RUN_POS       4
`define RFT_MASK_POS      0
`define RFT_T0CFG_RESET   8'h00
`define RFT_RLD_RESET     16'h0000
`define RFT_FAST_HZ       13560000
`define RFT_SLOW_HZ       211875
`define RFT_SLOW_DIV      (`RFT_FAST_HZ / `RFT_SLOW_HZ)
`endif

// ===== hdl/rf_timer_pkg.sv
// types shared by the timer section
package rf_timer_pkg;
  typedef enum logic [1:0] {
    START_MANUAL    = 2'h0,
    START_TX_END    = 2'h1,
    START_LFO       = 2'h2,
    START_LFO_UFLOW = 2'h3
  } start_mode_type;

  typedef enum logic [1:0] {
    CLK_FAST   = 2'h0,
    CLK_SLOW   = 2'h1,
    CLK_TIMER2 = 2'h2,
    CLK_TIMER1 = 2'h3
  } input_clock_type;

  typedef struct packed {
    logic            stopOnReceive;
    logic            rsvd6;
    start_mode_type  startModeSelect;
    logic            autoReloadEnable;
    logic            rsvd2;
    input_clock_type inputClockSelect;
  } timer_zero_config_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic        write;
    logic [31:0] wdata;
  } apb_request_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;
endpackage : rf_timer_pkg

// ===== testbench/rf_frontend_timer_control_props.sv
// assertion checker for the timer section ports
`timescale 1ns/1ps
module rf_frontend_timer_control_props (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic [3:0]  timerRunning
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic done;
  logic wrDone;
  logic mapped;
  logic runWr;
  assign done    = psel && penable && pready;
  assign wrDone  = done && pwrite;
  assign runWr   = wrDone && paddr[7:2] == 6'h0e;
  assign mapped  = (paddr[7:2] >= 6'h0e && paddr[7:2] <= 6'h13) || (paddr[7:2] >= 6'h20 && paddr[7:2] <= 6'h25);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_run_wr; runWr; endsequence
  property p_answer; s_access |=> pready; endproperty
  property p_cause; pready |-> psel && penable; endproperty
  property p_masked; s_run_wr |=> ((timerRunning ^ $past(pwdata[7:4])) & $past(pwdata[3:0])) == 4'h0; endproperty
  property p_start; |(timerRunning[3:1] & ~$past(timerRunning[3:1])) |-> $past(runWr); endproperty
  property p_unmapped; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
  property p_mapped; pready && mapped |-> !pslverr; endproperty
  property p_clr_read; pready && !pwrite && paddr[7:2] == 6'h22 |-> prdata == 32'h0; endproperty
  // irq only drops after software touches enable or clear
  property p_irq_fall; $fell(irq) |-> $past(wrDone, 1) || $past(wrDone, 2) || $past(wrDone, 3); endproperty
  a_answer: assert property (p_answer) else $error("pready late");
  a_cause: assert property (p_cause) else $error("pready without access");
  a_masked: assert property (p_masked) else $error("masked run bit wrong");
  a_start: assert property (p_start) else $error("timer started without write");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  a_clr_read: assert property (p_clr_read) else $error("clear register not zero");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
endmodule : rf_frontend_timer_control_props

bind rf_frontend_timer_control rf_frontend_timer_control_props i_rf_frontend_timer_control_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .timerRunning(timerRunning));

// ===== testbench/tb.sv
// self-checking bench for the timer section
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  timerRunning;
  logic        rfCarrier = 1'b0;
  logic        lfoPin = 1'b0;
  logic        txEnd = 1'b0;
  logic        rxFirstBits = 1'b0;
  logic        carrierOn = 1'b0;
  logic [1:0]  phase = 2'h0;
  logic [31:0] rd;
  logic        lastErr;
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          k;
  always #5 clk = ~clk;
  rf_frontend_timer_control i_rf_frontend_timer_control (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rfCarrier(rfCarrier),
    .lfoPin(lfoPin), .txEnd(txEnd), .rxFirstBits(rxFirstBits), .irq(irq), .timerRunning(timerRunning));
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // carrier stands still while off, otherwise timer0 would underflow on its own
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (carrierOn) rfCarrier <= phase[1];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0);
    check(what, rd, exp);
  endtask : rdc
  task automatic run_is(input logic [3:0] exp, input string what);
    repeat (2) @(posedge clk);
    check(what, {28'h0, timerRunning}, {28'h0, exp});
  endtask : run_is
  // lfo level is held for several cycles so the synchroniser sees it
  task automatic pulse(input int which);
    @(posedge clk);
    txEnd <= (which == 0);
    rxFirstBits <= (which == 1);
    lfoPin <= (which == 2);
    @(posedge clk);
    txEnd <= 1'b0;
    rxFirstBits <= 1'b0;
    repeat (4) @(posedge clk);
    lfoPin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdc(8'h38, 32'h0, "run reset");
    rdc(8'h3c, 32'h0, "config reset");
    apb(8'h3c, 1'b1, 32'hff);
    rdc(8'h3c, 32'hbb, "config fields");
    apb(8'h3c, 1'b1, 32'h00);
    apb(8'h38, 1'b1, 32'hf0);
    rdc(8'h38, 32'h0, "mask zero");
    apb(8'h38, 1'b1, 32'hf6);
    run_is(4'h6, "start two");
    apb(8'h38, 1'b1, 32'h04);
    rdc(8'h38, 32'h20, "stop one");
    apb(8'h38, 1'b1, 32'h0f);
    apb(8'h00, 1'b0, 32'h0);
    check("unmapped err", {31'h0, lastErr}, 32'h1);
    apb(8'h84, 1'b1, 32'h1);
    apb(8'h44, 1'b1, 32'h03);
    apb(8'h38, 1'b1, 32'h11);
    rdc(8'h4c, 32'h03, "count loaded");
    apb(8'h44, 1'b1, 32'h09);
    rdc(8'h4c, 32'h03, "count kept");
    carrierOn <= 1'b1;
    for (k = 0; k < 300 && timerRunning[0] === 1'b1; k++) @(posedge clk);
    run_is(4'h0, "stop at zero");
    check("irq set", {31'h0, irq}, 32'h1);
    rdc(8'h80, 32'h1, "status set");
    apb(8'h84, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(8'h84, 1'b1, 32'h1);
    apb(8'h88, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc(8'h80, 32'h0, "status cleared");
    apb(8'h3c, 1'b1, 32'h08);
    apb(8'h38, 1'b1, 32'h11);
    repeat (200) @(posedge clk);
    run_is(4'h1, "auto reload runs");
    rdc(8'h80, 32'h1, "auto underflow");
    apb(8'h38, 1'b1, 32'h01);
    carrierOn <= 1'b0;
    apb(8'h3c, 1'b1, 32'h10);
    pulse(0);
    run_is(4'h1, "tx end start");
    apb(8'h38, 1'b1, 32'h01);
    apb(8'h3c, 1'b1, 32'h00);
    pulse(0);
    run_is(4'h0, "manual no start");
    apb(8'h3c, 1'b1, 32'h80);
    apb(8'h38, 1'b1, 32'h11);
    pulse(1);
    run_is(4'h0, "rx stop");
    apb(8'h3c, 1'b1, 32'h00);
    apb(8'h38, 1'b1, 32'h11);
    pulse(1);
    run_is(4'h1, "rx no stop");
    apb(8'h3c, 1'b1, 32'hb0);
    pulse(1);
    run_is(4'h1, "rx ignored lfo");
    apb(8'h38, 1'b1, 32'h01);
    apb(8'h3c, 1'b1, 32'ha0);
    pulse(2);
    run_is(4'h1, "lfo edge start");
    pulse(2);
    run_is(4'h0, "lfo edge stop");
    apb(8'h3c, 1'b1, 32'h01);
    apb(8'h44, 1'b1, 32'h01);
    apb(8'h38, 1'b1, 32'h11);
    carrierOn <= 1'b1;
    repeat (200) @(posedge clk);
    run_is(4'h1, "slow clock runs");
    for (k = 0; k < 800 && timerRunning[0] === 1'b1; k++) @(posedge clk);
    run_is(4'h0, "slow clock stops");
    apb(8'h3c, 1'b1, 32'h02);
    apb(8'h44, 1'b1, 32'h00);
    apb(8'h8c, 1'b1, 32'h2);
    apb(8'h90, 1'b1, 32'h2);
    apb(8'h38, 1'b1, 32'h11);
    apb(8'h38, 1'b1, 32'h22);
    repeat (40) @(posedge clk);
    run_is(4'h1, "cascade ignores timer1");
    apb(8'h38, 1'b1, 32'h44);
    repeat (40) @(posedge clk);
    run_is(4'h0, "cascade timer2");
    apb(8'h3c, 1'b1, 32'h03);
    apb(8'h38, 1'b1, 32'h11);
    apb(8'h38, 1'b1, 32'h22);
    repeat (40) @(posedge clk);
    run_is(4'h0, "cascade timer1");
    apb(8'h88, 1'b1, 32'hf);
    apb(8'h3c, 1'b1, 32'h20);
    pulse(2);
    repeat (40) @(posedge clk);
    run_is(4'h1, "lfo holds at zero");
    rdc(8'h80, 32'h0, "lfo no underflow");
    stop_test();
  end
endmodule : tb
